// file: hw/host_interface_mode_select.sv
// Host interface mode selection and shared pin multiplexing.
// Function
// [RQ1] Read strobe, write strobe and style pins are caught as reset ends.
// [RQ2] Straps decode to style-high parallel, style-low parallel, I2C or SPI.
// [RQ3] Exactly one host interface is active at any time; none is active until the straps are caught after reset.
// [RQ4] The attention request pin only ever pulls low in every mode.
// [RQ5] In I2C mode the bidirectional data pin only drives low.
// [RQ6] Without parallel mode the multipurpose pins stay released until set.
// [RQ7] Outside parallel mode the far side holds the multipurpose pins.
// [RQ8] SPI uses select, clock, data in, data out and attention request.
// [RQ9] Host traffic reaches firmware as raw bytes, never as registers.
// [RQ10] Multipurpose pins are the parallel port or the memory interface.
// [RQ11] The external memory interface exists only in a serial mode.
// [RQ12] In serial modes the attention pin is caught as the autoboot select.
// [RQ13] The caught selection holds until the next reset.
`timescale 1ns/1ps

module host_interface_mode_select
  import host_mode_pkg::*;
(
  input wire logic clock,                       // 10 MHz system clock.
  input wire logic rst,                         // Sync reset, active high.
  input wire logic read_strobe_n_in,            // Read strobe pin level.
  input wire logic write_strobe_n_in,           // Write strobe pin level.
  input wire logic chip_select_n_in,            // SPI chip select pin.
  input wire logic serial_control_clock,        // Serial clock pin.
  input wire logic serial_control_in,           // SPI data in pin.
  input wire logic bidir_in,                    // Style strap / data pin.
  output logic bidir_out,                       // Style / data pin value.
  output logic bidir_oe,                        // Style / data pin enable.
  input wire logic attention_in,                // Attention pin level.
  output logic attention_out,                   // Attention pin value.
  output logic attention_oe,                    // Attention pin enable.
  input wire logic [GPIO_WIDTH-1:0] gpio_in,    // Multipurpose pin levels.
  output logic [GPIO_WIDTH-1:0] gpio_out,       // Multipurpose pin values.
  output logic [GPIO_WIDTH-1:0] gpio_oe,        // Multipurpose pin enables.
  input wire logic host_attention_request,      // Core has outgoing data.
  input wire logic serial_data_low,             // Core pulls I2C data low.
  input wire logic serial_control_out,          // Core SPI output bit.
  input wire logic [PORT_WIDTH-1:0] port_data,  // Core parallel read data.
  input wire logic port_drive,                  // Core drives parallel bus.
  input wire logic [PORT_WIDTH-1:0] ext_memory_addr_data, // Memory bus out.
  input wire logic ext_memory_drive,            // Core drives memory bus.
  input wire logic ext_memory_request,          // Firmware wants memory.
  input wire logic [GPIO_WIDTH-1:0] fw_gpio_out,  // Firmware pin values.
  input wire logic [GPIO_WIDTH-1:0] fw_gpio_oe,   // Firmware pin enables.
  input wire logic fw_gpio_assigned,            // Firmware owns the pins.
  output logic [2:0] host_mode,                 // Selected host mode code.
  output logic mode_valid,                      // Selection has been caught.
  output logic autoboot_select,                 // High: host downloads code.
  output logic ext_memory_active,               // Memory interface is live.
  output logic link_select_n,                   // SPI select to the core.
  output logic link_clock,                      // Serial clock to the core.
  output logic link_data_in,                    // Serial data to the core.
  output logic port_read_n,                     // Parallel read strobe.
  output logic port_write_n,                    // Parallel write strobe.
  output logic [GPIO_WIDTH-1:0] gpio_to_core    // Multipurpose pin samples.
);

  // ---------------------------------------------------------------------
  // Strap decoding
  // ---------------------------------------------------------------------

  // Both strobes low is not a documented pattern; read low wins and
  // the part comes up in I2C so that one interface is still chosen.
  function automatic host_mode_t decode_straps(input logic rd_n,
                                               input logic wr_n,
                                               input logic style);
    host_mode_t m;
    m = MODE_I2C;
    if (rd_n == STRAP_HIGH && wr_n == STRAP_HIGH)
    begin
      m = (style == STRAP_HIGH) ? MODE_PAR_STYLE_HI : MODE_PAR_STYLE_LO;
    end
    else if (rd_n == STRAP_HIGH && wr_n == STRAP_LOW)
    begin
      m = MODE_SPI;
    end
    return m;
  endfunction : decode_straps

  // True for either byte-wide parallel mode.
  function automatic logic is_parallel(input host_mode_t m);
    return (m == MODE_PAR_STYLE_HI) || (m == MODE_PAR_STYLE_LO);
  endfunction : is_parallel

  // True for either serial mode.
  function automatic logic is_serial(input host_mode_t m);
    return (m == MODE_I2C) || (m == MODE_SPI);
  endfunction : is_serial

  // ---------------------------------------------------------------------
  // Mode capture state
  // ---------------------------------------------------------------------
  host_mode_t mode_d;
  host_mode_t mode_q;
  logic autoboot_d;
  logic autoboot_q;
  logic valid_d;
  logic valid_q;

  // The straps are sampled on the first edge after reset falls; under a
  // synchronous reset the flops cannot take a pin level while held.
  always_comb
  begin
    mode_d = mode_q;
    autoboot_d = autoboot_q;
    case (mode_q)
      MODE_UNSET:
      begin
        // [RQ1] catch straps
        // [RQ2] decode strap pattern
        mode_d = decode_straps(read_strobe_n_in, write_strobe_n_in,
                               bidir_in);
        // [RQ12] autoboot strap catch
        autoboot_d = is_serial(mode_d) ? attention_in : STRAP_HIGH;
      end
      // [RQ13] selection held
      MODE_PAR_STYLE_HI, MODE_PAR_STYLE_LO, MODE_I2C, MODE_SPI:
        mode_d = mode_q;
      default:
        mode_d = MODE_UNSET;
    endcase
    valid_d = (mode_d != MODE_UNSET);
  end

  // [RQ3] single mode register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_q <= MODE_UNSET;
      autoboot_q <= STRAP_HIGH;
      valid_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      autoboot_q <= autoboot_d;
      valid_q <= valid_d;
    end
  end

  // ---------------------------------------------------------------------
  // Attention request pin
  // ---------------------------------------------------------------------

  // [RQ4] open-drain attention
  open_drain_pad attention_pad (
    .clock(clock),
    .rst(rst),
    .enable(mode_q != MODE_UNSET),
    .pull_low(host_attention_request),
    .pad_out(attention_out),
    .pad_oe(attention_oe)
  );

  // ---------------------------------------------------------------------
  // Shared pin and core-side routing
  // ---------------------------------------------------------------------
  logic bidir_out_d;
  logic bidir_out_q;
  logic bidir_oe_d;
  logic bidir_oe_q;
  logic [GPIO_WIDTH-1:0] gpio_out_d;
  logic [GPIO_WIDTH-1:0] gpio_out_q;
  logic [GPIO_WIDTH-1:0] gpio_oe_d;
  logic [GPIO_WIDTH-1:0] gpio_oe_q;
  logic [GPIO_WIDTH-1:0] gpio_core_d;
  logic [GPIO_WIDTH-1:0] gpio_core_q;
  logic mem_active_d;
  logic mem_active_q;
  logic select_n_d;
  logic select_n_q;
  logic clock_d;
  logic clock_q;
  logic data_in_d;
  logic data_in_q;
  logic read_n_d;
  logic read_n_q;
  logic write_n_d;
  logic write_n_q;

  // All pins stay released until a mode exists; routing follows mode_q.
  always_comb
  begin
    bidir_out_d = PIN_LOW;
    bidir_oe_d = PIN_RELEASED;
    // [RQ6] released by default
    gpio_out_d = GPIO_ZERO;
    gpio_oe_d = GPIO_RELEASED;
    gpio_core_d = GPIO_ZERO;
    mem_active_d = 1'b0;
    select_n_d = SELECT_IDLE_N;
    clock_d = PIN_LOW;
    data_in_d = PIN_LOW;
    read_n_d = SELECT_IDLE_N;
    write_n_d = SELECT_IDLE_N;
    // [RQ11] memory only in serial
    if (is_serial(mode_q))
      mem_active_d = ext_memory_request | (autoboot_q == STRAP_LOW);
    // [RQ9] raw pin bytes to firmware
    gpio_core_d = gpio_in;
    case (mode_q)
      MODE_PAR_STYLE_HI, MODE_PAR_STYLE_LO:
      begin
        // [RQ10] parallel host port
        read_n_d = read_strobe_n_in;
        write_n_d = write_strobe_n_in;
        gpio_out_d[PORT_WIDTH-1:0] = port_data;
        gpio_oe_d[PORT_WIDTH-1:0] = {PORT_WIDTH{port_drive}};
      end
      MODE_I2C:
      begin
        clock_d = serial_control_clock;
        data_in_d = bidir_in;
        // [RQ5] open-drain data line
        bidir_oe_d = serial_data_low;
      end
      MODE_SPI:
      begin
        // [RQ8] five-line serial link
        select_n_d = chip_select_n_in;
        clock_d = serial_control_clock;
        data_in_d = serial_control_in;
        bidir_out_d = serial_control_out;
        bidir_oe_d = ~chip_select_n_in;
      end
      default:
        gpio_core_d = GPIO_ZERO;
    endcase
    // [RQ10] memory bus or firmware use
    if (is_serial(mode_q))
    begin
      if (fw_gpio_assigned)
      begin
        gpio_out_d = fw_gpio_out;
        gpio_oe_d = fw_gpio_oe;
      end
      if (mem_active_d)
      begin
        gpio_out_d[PORT_WIDTH-1:0] = ext_memory_addr_data;
        gpio_oe_d[PORT_WIDTH-1:0] = {PORT_WIDTH{ext_memory_drive}};
      end
    end
  end

  // Every pin and core-facing output is registered for clean timing.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bidir_out_q <= PIN_LOW;
      bidir_oe_q <= PIN_RELEASED;
      gpio_out_q <= GPIO_ZERO;
      gpio_oe_q <= GPIO_RELEASED;
      gpio_core_q <= GPIO_ZERO;
      mem_active_q <= 1'b0;
      select_n_q <= SELECT_IDLE_N;
      clock_q <= PIN_LOW;
      data_in_q <= PIN_LOW;
      read_n_q <= SELECT_IDLE_N;
      write_n_q <= SELECT_IDLE_N;
    end
    else
    begin
      bidir_out_q <= bidir_out_d;
      bidir_oe_q <= bidir_oe_d;
      gpio_out_q <= gpio_out_d;
      gpio_oe_q <= gpio_oe_d;
      gpio_core_q <= gpio_core_d;
      mem_active_q <= mem_active_d;
      select_n_q <= select_n_d;
      clock_q <= clock_d;
      data_in_q <= data_in_d;
      read_n_q <= read_n_d;
      write_n_q <= write_n_d;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign host_mode = mode_q;
  assign mode_valid = valid_q;
  assign autoboot_select = autoboot_q;
  assign ext_memory_active = mem_active_q;
  assign bidir_out = bidir_out_q;
  assign bidir_oe = bidir_oe_q;
  assign gpio_out = gpio_out_q;
  assign gpio_oe = gpio_oe_q;
  assign gpio_to_core = gpio_core_q;
  assign link_select_n = select_n_q;
  assign link_clock = clock_q;
  assign link_data_in = data_in_q;
  assign port_read_n = read_n_q;
  assign port_write_n = write_n_q;

endmodule : host_interface_mode_select

// file: common/host_mode_pkg.sv
// Constants and types shared by the host interface mode selection logic.
package host_mode_pkg;

  // ---------------------------------------------------------------------
  // Widths of the shared pin groups
  // ---------------------------------------------------------------------
  localparam int GPIO_WIDTH = 12;
  localparam int PORT_WIDTH = 8;

  // ---------------------------------------------------------------------
  // Strap levels and pin reset values
  // ---------------------------------------------------------------------
  localparam logic STRAP_HIGH = 1'b1;
  localparam logic STRAP_LOW = 1'b0;
  localparam logic PIN_RELEASED = 1'b0;
  localparam logic PIN_LOW = 1'b0;
  localparam logic SELECT_IDLE_N = 1'b1;
  localparam logic [GPIO_WIDTH-1:0] GPIO_RELEASED = 12'h000;
  localparam logic [GPIO_WIDTH-1:0] GPIO_ZERO = 12'h000;
  localparam logic [GPIO_WIDTH-PORT_WIDTH-1:0] GPIO_UPPER_RELEASED = 4'h0;

  // ---------------------------------------------------------------------
  // Host interface modes
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_UNSET = 3'b000,
    MODE_PAR_STYLE_HI = 3'b001,
    MODE_PAR_STYLE_LO = 3'b010,
    MODE_I2C = 3'b011,
    MODE_SPI = 3'b100
  } host_mode_t;

endpackage : host_mode_pkg

// file: hw/open_drain_pad.sv
// Registered open-drain pad driver that can only pull its pin low.
`timescale 1ns/1ps

module open_drain_pad
  import host_mode_pkg::*;
(
  input wire logic clock,     // System clock.
  input wire logic rst,       // Synchronous reset, active high.
  input wire logic enable,    // Pad function is live.
  input wire logic pull_low,  // Request to pull the pin low.
  output logic pad_out,       // Pin output value, always low.
  output logic pad_oe         // Pin output enable, high while pulling.
);

  logic oe_d;
  logic oe_q;

  // ---------------------------------------------------------------------
  // Drive control
  // ---------------------------------------------------------------------

  // A one is never driven; the external pull-up supplies it.
  always_comb
  begin
    oe_d = enable & pull_low;
  end

  // Registered so the pin follows the clock, released during reset.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      oe_q <= PIN_RELEASED;
    end
    else
    begin
      oe_q <= oe_d;
    end
  end

  assign pad_out = PIN_LOW;
  assign pad_oe = oe_q;

endmodule : open_drain_pad

// file: verification/host_mode_monitor.sv
// Concurrent checks on the host interface mode selection ports.
`timescale 1ns/1ps
module host_mode_monitor
  import host_mode_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic read_strobe_n_in, // Strap.
  input wire logic write_strobe_n_in, // Strap.
  input wire logic chip_select_n_in, // Select.
  input wire logic bidir_in, // Strap.
  input wire logic bidir_out, // Value.
  input wire logic bidir_oe, // Enable.
  input wire logic attention_in, // Strap.
  input wire logic attention_out, // Value.
  input wire logic attention_oe, // Enable.
  input wire logic [GPIO_WIDTH-1:0] gpio_oe, // Enables.
  input wire logic host_attention_request, // Request.
  input wire logic serial_data_low, // Pull.
  input wire logic serial_control_out, // Bit.
  input wire logic port_drive, // Drive.
  input wire logic fw_gpio_assigned, // Owned.
  input wire logic [2:0] host_mode, // Mode.
  input wire logic mode_valid, // Caught.
  input wire logic autoboot_select, // Boot.
  input wire logic ext_memory_active // Memory.
);
  logic serial;
  logic par;

  // Mode classes used by several checks.
  assign serial = host_mode == MODE_I2C || host_mode == MODE_SPI;
  assign par = host_mode == MODE_PAR_STYLE_HI ||
    host_mode == MODE_PAR_STYLE_LO;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Both strobes low falls to I2C, so the read strobe is tested first.
  function automatic logic [2:0] decode(input logic r, w, s);
    if (!r)
      return 3'h3;
    if (!w)
      return 3'h4;
    return s ? 3'h1 : 3'h2;
  endfunction : decode

  a_strap_decode: assert property (
    $past(rst) |=> host_mode == decode($past(read_strobe_n_in),
    $past(write_strobe_n_in), $past(bidir_in)))
    else $error("host mode differs from the straps");
  a_autoboot_strap: assert property (
    $past(rst) |=> autoboot_select == (serial ? $past(attention_in) : 1'b1))
    else $error("autoboot select differs from the strap");
  a_single_mode: assert property (
    mode_valid == (host_mode != MODE_UNSET) && host_mode <= MODE_SPI)
    else $error("host mode code is not one single mode");
  a_mode_hold: assert property (
    mode_valid |=> $stable(host_mode))
    else $error("host mode changed without reset");
  a_attn_pull: assert property (
    mode_valid && host_attention_request |=> attention_oe)
    else $error("attention request not pulled low");
  a_attn_open: assert property (
    attention_oe |-> !attention_out && $past(host_attention_request))
    else $error("attention pin driven without cause");
  a_i2c_drain: assert property (
    host_mode == MODE_I2C && $past(host_mode) == MODE_I2C |->
    bidir_oe == $past(serial_data_low) && !(bidir_oe && bidir_out))
    else $error("data line is not open drain");
  a_spi_lines: assert property (
    host_mode == MODE_SPI && $past(host_mode) == MODE_SPI |->
    bidir_oe == !$past(chip_select_n_in) &&
    (!bidir_oe || bidir_out == $past(serial_control_out)))
    else $error("serial output line misrouted");
  a_par_port: assert property (
    par && $past(par) |-> gpio_oe == {4'h0, {8{$past(port_drive)}}} &&
    !bidir_oe && !ext_memory_active)
    else $error("parallel port pins misrouted");
  a_gpio_release: assert property (
    serial && $past(serial) && !$past(fw_gpio_assigned) |->
    gpio_oe == GPIO_ZERO)
    else $error("multipurpose pins driven before assignment");
endmodule : host_mode_monitor

// file: verification/host_model.sv
// Host-side model: strap levels, pull-ups and multipurpose pin levels.
`timescale 1ns/1ps
module host_model
(
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic [3:0] strap_code, // Read, write, style, boot.
  input wire logic bidir_out, // Device value.
  input wire logic bidir_oe, // Device enable.
  input wire logic attention_oe, // Device enable.
  output logic read_strobe_n_in, // Read pin.
  output logic write_strobe_n_in, // Write pin.
  output logic bidir_in, // Data pin.
  output logic attention_in, // Attention pin.
  output logic [11:0] gpio_in // Multipurpose pins.
);
  logic hold_q;

  // Straps stay put through the release edge, then the host moves on.
  always_ff @(posedge clock)
    hold_q <= rst;

  assign read_strobe_n_in = hold_q | rst ? strap_code[3] : ~strap_code[3];
  assign write_strobe_n_in = hold_q | rst ? strap_code[2] : ~strap_code[2];
  assign bidir_in = bidir_oe ? bidir_out :
    (hold_q | rst ? strap_code[1] : 1'b1);
  assign attention_in = attention_oe ? 1'b0 :
    (hold_q | rst ? strap_code[0] : 1'b1);
  assign gpio_in = 12'ha5c;
endmodule : host_model

// file: verification/tb_host_interface_mode_select.sv
// Self-checking bench for the host interface mode selection block.
`timescale 1ns/1ps
module tb_host_interface_mode_select;
  import host_mode_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] strap = 4'he;
  logic chip_select_n_in = 1'b1;
  logic serial_control_out = 1'b0;
  logic serial_data_low = 1'b0;
  logic host_attention_request = 1'b0;
  logic port_drive = 1'b0;
  logic ext_memory_request = 1'b0;
  logic fw_gpio_assigned = 1'b0;
  logic [7:0] port_data = 8'h00;
  logic [11:0] fw_gpio_oe = 12'h000;
  logic [11:0] fw_gpio_out = 12'h000;
  logic ext_memory_drive = 1'b0;
  logic [7:0] ext_memory_addr_data = 8'h00;
  logic serial_control_clock = 1'b0;
  logic serial_control_in = 1'b0;
  logic link_select_n, link_clock, link_data_in, port_read_n, port_write_n;
  logic [11:0] gpio_to_core;
  wire logic read_strobe_n_in, write_strobe_n_in, bidir_in, attention_in;
  wire logic [11:0] gpio_in;
  logic bidir_out, bidir_oe, attention_out, attention_oe;
  logic mode_valid, autoboot_select, ext_memory_active;
  logic [11:0] gpio_out, gpio_oe;
  logic [2:0] host_mode;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  host_interface_mode_select uut (.clock(clock), .rst(rst),
    .read_strobe_n_in(read_strobe_n_in), .write_strobe_n_in(write_strobe_n_in),
    .chip_select_n_in(chip_select_n_in),
    .serial_control_clock(serial_control_clock),
    .serial_control_in(serial_control_in), .bidir_in(bidir_in),
    .bidir_out(bidir_out),
    .bidir_oe(bidir_oe), .attention_in(attention_in),
    .attention_out(attention_out), .attention_oe(attention_oe),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .host_attention_request(host_attention_request),
    .serial_data_low(serial_data_low), .serial_control_out(serial_control_out),
    .port_data(port_data), .port_drive(port_drive),
    .ext_memory_addr_data(ext_memory_addr_data),
    .ext_memory_drive(ext_memory_drive),
    .ext_memory_request(ext_memory_request), .fw_gpio_out(fw_gpio_out),
    .fw_gpio_oe(fw_gpio_oe), .fw_gpio_assigned(fw_gpio_assigned),
    .host_mode(host_mode), .mode_valid(mode_valid),
    .autoboot_select(autoboot_select), .ext_memory_active(ext_memory_active),
    .link_select_n(link_select_n), .link_clock(link_clock),
    .link_data_in(link_data_in), .port_read_n(port_read_n),
    .port_write_n(port_write_n), .gpio_to_core(gpio_to_core));

  host_model host (.clock(clock), .rst(rst), .strap_code(strap),
    .bidir_out(bidir_out), .bidir_oe(bidir_oe), .attention_oe(attention_oe),
    .read_strobe_n_in(read_strobe_n_in), .write_strobe_n_in(write_strobe_n_in),
    .bidir_in(bidir_in), .attention_in(attention_in), .gpio_in(gpio_in));

  // Free-running 10 MHz clock.
  always #50 clock = ~clock;

  // Cut a hung run short; all tests need well under this many cycles.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Reset for four cycles with new straps, then let the routing settle.
  task automatic boot(input logic [3:0] s);
    @(negedge clock);
    rst = 1'b1;
    strap = s;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
  endtask : boot

  // Seven strap patterns, with the boot strap and memory side effect.
  task automatic t_straps();
    logic [3:0] s [7] = '{4'he, 4'hd, 4'h7, 4'h4, 4'hb, 4'h8, 4'h3};
    logic [3:0] x [7] = '{4'h3, 4'h5, 4'h7, 4'h6, 4'h9, 4'h8, 4'h7};
    for (int i = 0; i < 7; i++)
    begin
      boot(s[i]);
      repeat (4) @(negedge clock);
      chk("host_mode", 12'(x[i][3:1]), 12'(host_mode));
      chk("autoboot", 12'(x[i][0]), 12'(autoboot_select));
      chk("mem_act", 12'(x[i] == 4'h6 || x[i] == 4'h8),
        12'(ext_memory_active));
    end
    $display("test straps done");
  endtask : t_straps

  task automatic t_attention();
    host_attention_request = 1'b1;
    @(negedge clock);
    chk("attn_oe", 12'h001, 12'(attention_oe));
    chk("attn_pin", 12'h000, 12'(attention_in));
    host_attention_request = 1'b0;
    @(negedge clock);
    chk("attn_pin", 12'h001, 12'(attention_in));
    $display("test attention done");
  endtask : t_attention

  task automatic t_i2c();
    boot(4'h7);
    serial_data_low = 1'b1;
    @(negedge clock);
    chk("data_pin", 12'h000, 12'(bidir_in));
    serial_data_low = 1'b0;
    @(negedge clock);
    chk("data_oe", 12'h000, 12'(bidir_oe));
    chk("i2c_in", 12'h000, 12'(link_data_in));
    $display("test i2c done");
  endtask : t_i2c

  task automatic t_spi();
    boot(4'hb);
    {chip_select_n_in, serial_control_clock, serial_control_in} = 3'b011;
    serial_control_out = 1'b1;
    @(negedge clock);
    chk("spi_out", 12'h001, 12'({bidir_oe, bidir_out} == 2'b11));
    chk("link", 12'h3, 12'({link_select_n, link_clock, link_data_in}));
    chip_select_n_in = 1'b1;
    @(negedge clock);
    chk("spi_oe", 12'h000, 12'(bidir_oe));
    chk("sel_n", 12'h001, 12'(link_select_n));
    $display("test spi done");
  endtask : t_spi

  // Parallel port drive, then firmware and memory use in a serial mode.
  // The memory bus takes the low byte over from the firmware pins.
  task automatic t_pins();
    boot(4'hd);
    {port_drive, ext_memory_request, fw_gpio_assigned} = 3'b111;
    port_data = 8'h5a;
    fw_gpio_oe = 12'hfff;
    @(negedge clock);
    chk("gpio_oe", 12'h0ff, gpio_oe);
    chk("gpio_out", 12'h05a, {4'h0, gpio_out[7:0]});
    chk("mem_act", 12'h000, 12'(ext_memory_active));
    chk("strobes", 12'h000, 12'({port_read_n, port_write_n}));
    chk("to_core", 12'ha5c, gpio_to_core);
    {port_drive, ext_memory_request, fw_gpio_assigned} = 3'b000;
    boot(4'hb);
    chk("gpio_oe", 12'h000, gpio_oe);
    fw_gpio_assigned = 1'b1;
    fw_gpio_oe = 12'h3c3;
    fw_gpio_out = 12'h9a5;
    @(negedge clock);
    chk("gpio_oe", 12'h3c3, gpio_oe);
    chk("gpio_out", 12'h9a5, gpio_out);
    {ext_memory_request, ext_memory_drive} = 2'b11;
    ext_memory_addr_data = 8'hc3;
    @(negedge clock);
    chk("gpio_oe", 12'h3ff, gpio_oe);
    chk("gpio_out", 12'h9c3, gpio_out);
    chk("mem_act", 12'h001, 12'(ext_memory_active));
    $display("test pins done");
  endtask : t_pins

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial
  begin
    t_straps();
    t_attention();
    t_i2c();
    t_spi();
    t_pins();
    tally_and_finish();
  end
endmodule : tb_host_interface_mode_select

bind host_interface_mode_select host_mode_monitor mon (.clock(clock),
  .rst(rst), .read_strobe_n_in(read_strobe_n_in),
  .write_strobe_n_in(write_strobe_n_in), .chip_select_n_in(chip_select_n_in),
  .bidir_in(bidir_in), .bidir_out(bidir_out), .bidir_oe(bidir_oe),
  .attention_in(attention_in), .attention_out(attention_out),
  .attention_oe(attention_oe), .gpio_oe(gpio_oe),
  .host_attention_request(host_attention_request),
  .serial_data_low(serial_data_low), .serial_control_out(serial_control_out),
  .port_drive(port_drive), .fw_gpio_assigned(fw_gpio_assigned),
  .host_mode(host_mode), .mode_valid(mode_valid),
  .autoboot_select(autoboot_select), .ext_memory_active(ext_memory_active));
